//--- inc/vda_defines.svh
`ifndef VDA_DEFINES_SVH
`define VDA_DEFINES_SVH
// What this block does
// - Sixteen-byte store, layout set by mode
// - Dedicated-line mode takes only line 16
// - Packet mode accepts only 8/30 rows, or row 0 in header mode
// - Format 1 bytes stored unchanged
// - Format 2 Hamming checked, single errors corrected
// - Format 2 store drives data ready low
// - Biphase error blocks dedicated-line store
// - Dedicated-line store drives data ready low
// - Header mode A: bytes 38-45, 30-37
// - Header mode B: bytes 22-29, 14-21
// - New line refreshes store unless bus busy
// - Store readable at any time
// - First field flag high during field one
// - Address select picks 20/21 or 22/23
// - Test input high enables test mode
// - Oscillator 10 MHz or 13.875 MHz
// - Slicer averaging window per mode
// - Control bit 1 selects mode, reset zero
// - Control bit 0 selects format 2 or other
// - Control bit 2 selects format 1 or header
// - Control bit 3 selects header order
`define VDA_OFF_CTRL      8'h00
`define VDA_OFF_STATUS    8'h04
`define VDA_OFF_ADDR      8'h08
`define VDA_OFF_STORE     2'b01
`define VDA_CTRL_RST      8'h00
`define VDA_BIT_FMT       0
`define VDA_BIT_MODE      1
`define VDA_BIT_HDR       2
`define VDA_BIT_ORDER     3
`define VDA_I2C_ADDR_LO   8'h20
`define VDA_I2C_ADDR_HI   8'h22
`define VDA_DL_LINE       9'h010
`define VDA_DEW_FIRST     9'h007
`define VDA_DEW_LAST      9'h016
`define VDA_STORE_BYTES   6'h10
`define VDA_PKT_DATA0     6'h03
`define VDA_PKT_DATA_END  6'h13
`define VDA_HDR_BASE      7'h04
`define VDA_HDR_A_HI      7'h26
`define VDA_HDR_A_LO      7'h1e
`define VDA_HDR_B_HI      7'h16
`define VDA_HDR_B_LO      7'h0e
`define VDA_ROW_830       5'h1e
`define VDA_OSC_DL_KHZ    10000
`define VDA_OSC_PKT_KHZ   13875
`endif

//--- inc/vda_pkg.sv
package vda_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LINE = 3'b010,
        ST_DONE = 3'b100
    } vda_state_t;

    typedef enum logic [2:0] {
        K_NONE = 3'h0,
        K_PEND = 3'h1,
        K_F1   = 3'h2,
        K_F2   = 3'h3,
        K_HDR  = 3'h4
    } vda_kind_t;

    typedef struct packed {
        vda_state_t      st;
        vda_kind_t       kind;
        logic [7:0]      ctrl;
        logic [15:0][7:0] store;
        logic [15:0][7:0] stage;
        logic [15:0]     stage_vld;
        logic [7:0]      sh;
        logic [2:0]      bitn;
        logic [5:0]      idx;
        logic            half;
        logic            half_bit;
        logic            bip_err;
        logic            access_seen;
        logic            line_ok;
        logic            pkt;
        logic            data_entry_window;
        logic [3:0]      addr_lo;
        logic [8:0]      line_cnt;
        logic            clk_d;
        logic            hs_d;
        logic            vs_d;
        logic            drdy_n;
        logic            ack;
        logic [31:0]     rdata;
        logic            last_bip;
        logic            last_drop;
        logic            win;
        logic            ff;
    } vda_regs_t;
endpackage

//--- logic/vda_acq.sv
`timescale 1ns/100ps
`include "vda_defines.svh"
module vda_acq
    import vda_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        data_clk_i,
    input  wire logic        data_bit_i,
    input  wire logic        data_gate_i,
    input  wire logic        hsync_i,
    input  wire logic        vsync_i,
    input  wire logic        field_i,
    input  wire logic        runin_i,
    input  wire logic        bus_address_select_i,
    input  wire logic        test_mode_input_i,
    output logic             data_ready_n_o,
    output logic             first_field_flag_o,
    output logic             slice_window_o,
    output logic             osc_fast_sel_o
);
    vda_regs_t   r;
    vda_regs_t   n;
    logic [8:0]  sync_q;
    logic        clk_s;
    logic        bit_s;
    logic        gate_s;
    logic        hs_s;
    logic        vs_s;
    logic        field_s;
    logic        runin_s;
    logic        sel_s;
    logic        tst_s;
    logic        busy;
    logic        in_dew;
    logic [7:0]  new_byte;
    logic [3:0]  ham_nib;
    logic        ham_ok;
    logic [31:0] rd_word;
    vda_kind_t   want;

    vda_sync #(.W(9)) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .d_i        ({data_clk_i, data_bit_i, data_gate_i, hsync_i, vsync_i,
                      field_i, runin_i, bus_address_select_i, test_mode_input_i}),
        .q_o        (sync_q)
    );
    assign {clk_s, bit_s, gate_s, hs_s, vs_s, field_s, runin_s, sel_s, tst_s} = sync_q;

    // Packet bytes arrive LSB first, dedicated-line bytes MSB first
    assign new_byte = r.pkt ? {bit_s, r.sh[7:1]} : {r.sh[6:0], r.half_bit};

    vda_ham84 u_ham (
        .code_i (new_byte),
        .data_o (ham_nib),
        .ok_o   (ham_ok)
    );

    assign busy   = avs_read_i | avs_write_i;
    assign in_dew = (r.line_cnt >= `VDA_DEW_FIRST) && (r.line_cnt <= `VDA_DEW_LAST);

    always_comb
    begin
        if (!r.ctrl[`VDA_BIT_FMT])
            want = K_F2;
        else if (r.ctrl[`VDA_BIT_HDR])
            want = K_HDR;
        else
            want = K_F1;
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (avs_address_i == `VDA_OFF_CTRL)
            rd_word[7:0] = r.ctrl;
        else if (avs_address_i == `VDA_OFF_STATUS)
            rd_word[5:0] = {r.ff, r.last_drop, r.last_bip, tst_s, r.pkt, ~r.drdy_n};
        else if (avs_address_i == `VDA_OFF_ADDR)
            rd_word[7:0] = sel_s ? `VDA_I2C_ADDR_HI : `VDA_I2C_ADDR_LO;
        else if (avs_address_i[7:6] == `VDA_OFF_STORE && avs_address_i[1:0] == 2'b00)
            rd_word[7:0] = r.store[avs_address_i[5:2]];
    end

    always_comb
    begin
        logic [6:0] pos;
        logic [6:0] hi;
        logic [6:0] lo;
        logic [4:0] row;
        n   = r;
        pos = 7'(r.idx) + `VDA_HDR_BASE;
        hi  = r.ctrl[`VDA_BIT_ORDER] ? `VDA_HDR_B_HI : `VDA_HDR_A_HI;
        lo  = r.ctrl[`VDA_BIT_ORDER] ? `VDA_HDR_B_LO : `VDA_HDR_A_LO;
        row = {ham_nib, r.addr_lo[3]};

        n.clk_d = clk_s;
        n.hs_d  = hs_s;
        n.vs_d  = vs_s;
        n.ff    = field_s;
        // Averaging window: line 16, or run-in inside the entry window
        n.win   = r.ctrl[`VDA_BIT_MODE] ? (in_dew && runin_s)
                                        : (r.line_cnt == `VDA_DL_LINE);
        if (vs_s && !r.vs_d)
            n.line_cnt = 9'h000;
        else if (hs_s && !r.hs_d && r.line_cnt != 9'h1ff)
            n.line_cnt = r.line_cnt + 9'h001;

        n.ack = busy && !r.ack;
        if (busy && !r.ack)
            n.rdata = rd_word;
        if (r.ack && avs_write_i && avs_address_i == `VDA_OFF_CTRL && avs_byteenable_i[0])
        begin
            // Test bits only move while the test input is high
            n.ctrl[3:0] = avs_writedata_i[3:0];
            if (tst_s)
                n.ctrl[7:4] = avs_writedata_i[7:4];
        end
        if (r.ack && avs_read_i && avs_address_i == `VDA_OFF_STATUS)
            n.drdy_n = 1'b1;

        case (r.st)
            ST_IDLE:
            begin
                if (gate_s)
                begin
                    n.st          = ST_LINE;
                    n.idx         = 6'h00;
                    n.bitn        = 3'h0;
                    n.half        = 1'b0;
                    n.bip_err     = 1'b0;
                    n.access_seen = busy;
                    n.stage_vld   = 16'h0000;
                    n.kind        = K_NONE;
                    n.pkt         = r.ctrl[`VDA_BIT_MODE];
                    n.data_entry_window         = in_dew;
                    n.line_ok     = !r.ctrl[`VDA_BIT_MODE]
                                    && (r.line_cnt == `VDA_DL_LINE);
                end
            end
            ST_LINE:
            begin
                if (busy)
                    n.access_seen = 1'b1;
                if (!gate_s)
                    n.st = ST_DONE;
                else if (clk_s && !r.clk_d)
                begin
                    if (!r.pkt && !r.half)
                    begin
                        n.half     = 1'b1;
                        n.half_bit = bit_s;
                    end
                    else
                    begin
                        n.half = 1'b0;
                        if (!r.pkt && bit_s == r.half_bit)
                            n.bip_err = 1'b1;
                        n.sh   = new_byte;
                        n.bitn = r.bitn + 3'h1;
                        if (r.bitn == 3'h7)
                        begin
                            if (r.idx != 6'h3f)
                                n.idx = r.idx + 6'h01;
                            if (!r.pkt)
                            begin
                                if (r.idx < `VDA_STORE_BYTES)
                                begin
                                    n.stage[r.idx[3:0]]     = new_byte;
                                    n.stage_vld[r.idx[3:0]] = 1'b1;
                                end
                            end
                            else if (r.data_entry_window)
                            begin
                                if (r.idx == 6'h00)
                                begin
                                    n.addr_lo = ham_nib;
                                    n.data_entry_window     = ham_ok;
                                end
                                else if (r.idx == 6'h01)
                                begin
                                    if (!ham_ok)
                                        n.data_entry_window = 1'b0;
                                    else if (row == 5'h00 && want == K_HDR)
                                    begin
                                        n.kind    = K_HDR;
                                        n.line_ok = 1'b1;
                                    end
                                    else if (row == `VDA_ROW_830 && r.addr_lo[2:0] == 3'h0
                                             && want != K_HDR)
                                        n.kind = K_PEND;
                                    else
                                        n.data_entry_window = 1'b0;
                                end
                                else if (r.idx == 6'h02 && r.kind == K_PEND)
                                begin
                                    // Designation code tells format 1 from format 2
                                    if (ham_ok && ham_nib[3:1] == 3'h0 && want == K_F1)
                                    begin
                                        n.kind    = K_F1;
                                        n.line_ok = 1'b1;
                                    end
                                    else if (ham_ok && ham_nib[3:1] == 3'h1 && want == K_F2)
                                    begin
                                        n.kind    = K_F2;
                                        n.line_ok = 1'b1;
                                    end
                                    else
                                        n.data_entry_window = 1'b0;
                                end
                                else if (r.line_ok && r.kind == K_HDR)
                                begin
                                    if (pos >= hi && pos < hi + 7'h08)
                                    begin
                                        n.stage[4'(pos - hi)]     = new_byte;
                                        n.stage_vld[4'(pos - hi)] = 1'b1;
                                    end
                                    else if (pos >= lo && pos < lo + 7'h08)
                                    begin
                                        n.stage[4'(pos - lo + 7'h08)]     = new_byte;
                                        n.stage_vld[4'(pos - lo + 7'h08)] = 1'b1;
                                    end
                                end
                                else if (r.line_ok && r.idx >= `VDA_PKT_DATA0
                                         && r.idx < `VDA_PKT_DATA_END)
                                begin
                                    if (r.kind == K_F1)
                                    begin
                                        n.stage[4'(r.idx - `VDA_PKT_DATA0)] = new_byte;
                                        n.stage_vld[4'(r.idx - `VDA_PKT_DATA0)] = 1'b1;
                                    end
                                    else if (ham_ok)
                                    begin
                                        // Uncorrectable bytes keep the old store value
                                        n.stage[4'(r.idx - `VDA_PKT_DATA0)] = {4'h0, ham_nib};
                                        n.stage_vld[4'(r.idx - `VDA_PKT_DATA0)] = 1'b1;
                                    end
                                end
                            end
                        end
                    end
                end
            end
            ST_DONE:
            begin
                n.st        = ST_IDLE;
                n.last_bip  = !r.pkt && r.bip_err;
                n.last_drop = r.access_seen || busy;
                // Dropped, not queued: a stale line is worse than a missed one
                if (!busy && !r.access_seen && r.line_ok
                    && (r.pkt || (!r.bip_err && r.idx >= `VDA_STORE_BYTES)))
                begin
                    for (int i = 0; i < 16; i++)
                    begin
                        if (r.stage_vld[i])
                            n.store[i] = r.stage[i];
                    end
                    if (!r.pkt || r.kind == K_F2)
                        n.drdy_n = 1'b0;
                end
            end
            default:
                n.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            r        <= '0;
            r.st     <= ST_IDLE;
            r.kind   <= K_NONE;
            r.ctrl   <= `VDA_CTRL_RST;
            r.drdy_n <= 1'b1;
        end
        else
            r <= n;
    end

    assign avs_waitrequest_o  = busy && !r.ack;
    assign avs_readdata_o     = r.rdata;
    assign data_ready_n_o     = r.drdy_n;
    assign first_field_flag_o = r.ff;
    assign slice_window_o     = r.win;
    assign osc_fast_sel_o     = r.ctrl[`VDA_BIT_MODE];

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_busy_freeze;
        busy |=> $stable(r.store);
    endproperty
    a_busy_freeze: assert property (p_busy_freeze) else $error("store changed during access");

    property p_drop_line;
        (r.st == ST_DONE && r.access_seen) |=> $stable(r.store) && $stable(r.drdy_n);
    endproperty
    a_drop_line: assert property (p_drop_line) else $error("line kept after access");

    property p_bip_block;
        (r.st == ST_DONE && !r.pkt && r.bip_err) |=> $stable(r.store);
    endproperty
    a_bip_block: assert property (p_bip_block) else $error("biphase error line stored");

    property p_ready_fall;
        $fell(data_ready_n_o) |-> $past(r.st) == ST_DONE && ($past(r.kind) == K_F2 || !$past(r.pkt));
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("data ready fell without store");

    property p_line16;
        (r.st == ST_IDLE && gate_s && !r.ctrl[1] && r.line_cnt != `VDA_DL_LINE) |=> !r.line_ok;
    endproperty
    a_line16: assert property (p_line16) else $error("dedicated line accepted off line 16");

    property p_answer;
        (busy && avs_waitrequest_o) |=> !avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered in one wait");

    property p_addr_pair;
        (avs_read_i && !avs_waitrequest_o && avs_address_i == `VDA_OFF_ADDR)
            |-> avs_readdata_o[7:0] == ($past(sel_s) ? `VDA_I2C_ADDR_HI : `VDA_I2C_ADDR_LO);
    endproperty
    a_addr_pair: assert property (p_addr_pair) else $error("bus address pair wrong");

    property p_test_lock;
        (avs_write_i && !avs_waitrequest_o && !tst_s) |=> $stable(r.ctrl[7:4]);
    endproperty
    a_test_lock: assert property (p_test_lock) else $error("test bits moved outside test");

    c_vps_store: cover property (r.st == ST_DONE && !r.pkt && r.line_ok ##1 $fell(data_ready_n_o));
    c_f2_store:  cover property (r.st == ST_DONE && r.kind == K_F2 && !r.access_seen);
    c_hdr_store: cover property (r.st == ST_DONE && r.kind == K_HDR && r.stage_vld == 16'hffff);
    c_dropped:   cover property (r.st == ST_DONE && r.access_seen && r.line_ok);
endmodule

//--- logic/vda_ham84.sv
`timescale 1ns/100ps
module vda_ham84 (
    input  wire logic [7:0] code_i,
    output logic      [3:0] data_o,
    output logic            ok_o
);
    logic [2:0] syn;
    logic       par_bad;
    logic [3:0] d;

    // Odd-parity checks; a bad overall parity means one bit flipped
    always_comb
    begin
        syn[0]  = ~(code_i[0] ^ code_i[1] ^ code_i[5] ^ code_i[7]);
        syn[1]  = ~(code_i[2] ^ code_i[1] ^ code_i[3] ^ code_i[7]);
        syn[2]  = ~(code_i[4] ^ code_i[1] ^ code_i[3] ^ code_i[5]);
        par_bad = ~(^code_i);
        d       = {code_i[7], code_i[5], code_i[3], code_i[1]};
        if (par_bad)
        begin
            case (syn)
                3'b111:  d[0] = ~d[0];
                3'b110:  d[1] = ~d[1];
                3'b101:  d[2] = ~d[2];
                3'b011:  d[3] = ~d[3];
                default: d    = d;
            endcase
        end
        data_o = d;
        ok_o   = par_bad | (syn == 3'b000);
    end
endmodule

//--- logic/vda_sync.sv
`timescale 1ns/100ps
module vda_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            meta_ff <= '0;
            q_ff    <= '0;
        end
        else
        begin
            meta_ff <= d_i;
            q_ff    <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule

//--- test/vda_acq_tb.sv
`timescale 1ns/100ps
module vda_acq_tb;
    logic        core_clk_i           = 1'b0;
    logic        rst_i                = 1'b1;
    logic [7:0]  avs_address_i        = 8'h00;
    logic        avs_read_i           = 1'b0;
    logic        avs_write_i          = 1'b0;
    logic [31:0] avs_writedata_i      = 32'h0000_0000;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        data_clk;
    logic        data_bit;
    logic        data_gate;
    logic        hsync;
    logic        vsync;
    logic        field_i              = 1'b0;
    logic        bus_address_select_i = 1'b0;
    logic        test_mode_input_i    = 1'b0;
    logic        data_ready_n_o;
    logic        first_field_flag_o;
    logic [1:0]  so;
    logic [31:0] rdv;
    logic [7:0]  lb [0:47];
    logic [7:0]  es [0:15];
    int          error_cnt            = 0;
    int          samples_checked      = 0;

    always #12.5 core_clk_i = ~core_clk_i;

    vda_frontend_model u_fe (.core_clk_i(core_clk_i), .data_clk_o(data_clk),
        .data_bit_o(data_bit), .data_gate_o(data_gate), .hsync_o(hsync), .vsync_o(vsync));

    vda_acq u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .data_clk_i(data_clk), .data_bit_i(data_bit),
        .data_gate_i(data_gate), .hsync_i(hsync), .vsync_i(vsync), .field_i(field_i),
        .runin_i(1'b0), .bus_address_select_i(bus_address_select_i),
        .test_mode_input_i(test_mode_input_i), .data_ready_n_o(data_ready_n_o),
        .first_field_flag_o(first_field_flag_o), .slice_window_o(so[1]), .osc_fast_sel_o(so[0]));

    function automatic logic [7:0] pat(input int i);
        return 8'(i * 17 + 60);
    endfunction

    function automatic logic [7:0] ham(input int n);
        logic [7:0] t [0:15] = '{8'h15, 8'h02, 8'h49, 8'h5e, 8'h64, 8'h73, 8'h38, 8'h2f,
                                 8'hd0, 8'hc7, 8'h8c, 8'h9b, 8'ha1, 8'hb6, 8'hfd, 8'hea};
        return t[n % 16];
    endfunction

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_read_i      <= ~wr;
        avs_write_i     <= wr;
        avs_writedata_i <= wd;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (avs_waitrequest_o !== 1'b0 && n < 50);
        rdv = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            complete_run();
        end
        @(posedge core_clk_i);
    endtask

    task automatic chk_store(input logic [7:0] m);
        for (int k = 0; k < 16; k++)
        begin
            bus(1'b0, 8'(64 + 4 * k), 32'h0000_0000);
            check(rdv & {24'h00_0000, m}, {24'h00_0000, es[k] & m});
        end
    endtask

    task automatic run_line(input int ln, input int nb, input bit bip, input int bad);
        u_fe.send_line(ln, nb, bip, bad, lb);
        repeat (20) @(posedge core_clk_i);
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (data_ready_n_o !== 1'b0 && n < 100)
        begin
            @(posedge core_clk_i);
            n++;
        end
        check({31'h0000_0000, data_ready_n_o}, 32'h0000_0000);
    endtask

    initial
    begin
        repeat (90000) @(posedge core_clk_i);
        error_cnt++;
        complete_run();
    end

    initial
    begin
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        bus(1'b0, 8'h00, 32'h0000_0000);
        check(rdv, 32'h0000_0000);
        bus(1'b0, 8'h08, 32'h0000_0000);
        check(rdv, 32'h0000_0020);
        bus_address_select_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        bus(1'b0, 8'h08, 32'h0000_0000);
        check(rdv, 32'h0000_0022);
        bus(1'b0, 8'h0c, 32'h0000_0000);
        check(rdv, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h0000_00f0);
        bus(1'b0, 8'h00, 32'h0000_0000);
        check(rdv, 32'h0000_0000);
        test_mode_input_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        bus(1'b1, 8'h00, 32'h0000_00f0);
        bus(1'b0, 8'h00, 32'h0000_0000);
        check(rdv, 32'h0000_00f0);
        bus(1'b1, 8'h00, 32'h0000_0000);
        test_mode_input_i <= 1'b0;
        // Start in dedicated-line mode, as after power-on
        for (int i = 0; i < 48; i++)
            lb[i] = pat(i);
        for (int k = 0; k < 16; k++)
            es[k] = pat(k);
        run_line(16, 16, 1'b1, -1);
        wait_ready();
        chk_store(8'hff);
        check({30'h0000_0000, so}, 32'h0000_0002);
        bus(1'b0, 8'h04, 32'h0000_0000);
        check(rdv, 32'h0000_0001);
        check({31'h0000_0000, data_ready_n_o}, 32'h0000_0001);
        for (int i = 0; i < 48; i++)
            lb[i] = ~pat(i);
        run_line(16, 16, 1'b1, 37);
        check({31'h0000_0000, data_ready_n_o}, 32'h0000_0001);
        chk_store(8'hff);
        bus(1'b0, 8'h04, 32'h0000_0000);
        check(rdv, 32'h0000_0008);
        run_line(15, 16, 1'b1, -1);
        check({31'h0000_0000, data_ready_n_o}, 32'h0000_0001);
        chk_store(8'hff);
        fork
            run_line(16, 16, 1'b1, -1);
            begin
                repeat (600) @(posedge core_clk_i);
                bus(1'b0, 8'h00, 32'h0000_0000);
            end
        join
        check({31'h0000_0000, data_ready_n_o}, 32'h0000_0001);
        chk_store(8'hff);
        bus(1'b0, 8'h04, 32'h0000_0000);
        check(rdv, 32'h0000_0010);
        run_line(16, 16, 1'b1, -1);
        wait_ready();
        for (int k = 0; k < 16; k++)
            es[k] = ~pat(k);
        chk_store(8'hff);
        bus(1'b0, 8'h04, 32'h0000_0000);
        // Packet mode, format 1: magazine 0 row 30, designation 0
        bus(1'b1, 8'h00, 32'h0000_0003);
        for (int i = 0; i < 48; i++)
            lb[i] = pat(i);
        lb[0] = ham(0);
        lb[1] = ham(15);
        lb[2] = ham(0);
        run_line(16, 42, 1'b0, -1);
        check({31'h0000_0000, data_ready_n_o}, 32'h0000_0001);
        for (int k = 0; k < 16; k++)
            es[k] = pat(k + 3);
        chk_store(8'hff);
        check({30'h0000_0000, so}, 32'h0000_0001);
        // Format 2 with a correctable single-bit error in one byte
        bus(1'b1, 8'h00, 32'h0000_0002);
        for (int i = 0; i < 48; i++)
            lb[i] = ham(i);
        lb[1] = ham(15);
        lb[5] = lb[5] ^ 8'h02;
        run_line(16, 42, 1'b0, -1);
        wait_ready();
        for (int k = 0; k < 16; k++)
            es[k] = 8'((k + 3) % 16);
        chk_store(8'h0f);
        bus(1'b0, 8'h04, 32'h0000_0000);
        // Header row in both orders
        for (int o = 0; o < 2; o++)
        begin
            bus(1'b1, 8'h00, o ? 32'h0000_000f : 32'h0000_0007);
            for (int i = 0; i < 48; i++)
                lb[i] = pat(i);
            lb[0] = ham(0);
            lb[1] = ham(0);
            run_line(16, 42, 1'b0, -1);
            for (int k = 0; k < 16; k++)
                es[k] = pat((o ? (k < 8 ? 22 + k : 6 + k) : (k < 8 ? 38 + k : 22 + k)) - 4);
            chk_store(8'hff);
        end
        field_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        check({31'h0000_0000, first_field_flag_o}, 32'h0000_0001);
        bus(1'b0, 8'h04, 32'h0000_0000);
        check(rdv & 32'h0000_0020, 32'h0000_0020);
        complete_run();
    end
endmodule

//--- test/vda_frontend_model.sv
`timescale 1ns/100ps
module vda_frontend_model (
    input  wire logic core_clk_i,
    output logic      data_clk_o,
    output logic      data_bit_o,
    output logic      data_gate_o,
    output logic      hsync_o,
    output logic      vsync_o
);
    initial
    begin
        data_clk_o  = 1'b0;
        data_bit_o  = 1'b0;
        data_gate_o = 1'b0;
        hsync_o     = 1'b0;
        vsync_o     = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // 8 core clocks per link period, i.e. 200 ns
    task automatic send_half(input logic v);
        data_bit_o <= v;
        data_clk_o <= 1'b0;
        tick(4);
        data_clk_o <= 1'b1;
        tick(4);
    endtask

    // Biphase lines go MSB first in two halves; packet lines go LSB first
    task automatic send_line(input int ln, input int nb, input bit bip, input int bad,
                             input logic [7:0] b [0:47]);
        logic v;
        vsync_o <= 1'b1;
        tick(4);
        vsync_o <= 1'b0;
        tick(4);
        for (int i = 0; i < ln; i++)
        begin
            hsync_o <= 1'b1;
            tick(4);
            hsync_o <= 1'b0;
            tick(4);
        end
        data_gate_o <= 1'b1;
        tick(4);
        for (int i = 0; i < nb * 8; i++)
        begin
            v = bip ? b[i / 8][7 - i % 8] : b[i / 8][i % 8];
            send_half(v);
            if (bip)
                send_half((i == bad) ? v : ~v);
        end
        // Released line must not keep showing the last bit
        data_gate_o <= 1'b0;
        data_clk_o  <= 1'b0;
        data_bit_o  <= ~data_bit_o;
        tick(4);
    endtask
endmodule
